// ### hdl/msc_msi_cap.sv
// message interrupt capability registers and interrupt write former
// assumes vector requests come from logic on I_CLK and the write port
// accepts a request on the edge where valid and ready are both high
`timescale 1ns/1ps
module msc_msi_cap #(
   parameter logic       ADDR64  = 1'b1,
   parameter logic [2:0] MMC     = 3'h5
) (
   input  wire logic                       I_CLK,
   input  wire logic                       I_RSTN,
   input  wire logic [msc_pkg::ADDR_W-1:0] I_ADDRESS,
   input  wire logic                       I_READ,
   input  wire logic                       I_WRITE,
   input  wire logic [31:0]                I_WRITEDATA,
   input  wire logic [3:0]                 I_BYTEENABLE,
   output logic                            O_WAITREQUEST,
   output logic [31:0]                     O_READDATA,
   input  wire logic [msc_pkg::NVEC-1:0]   I_VEC_REQ,
   output logic                            O_MWR_VALID,
   output logic [63:0]                     O_MWR_ADDR,
   output logic [31:0]                     O_MWR_DATA,
   input  wire logic                       I_MWR_READY,
   output logic                            O_IRQ
);
   import msc_pkg::*;

   localparam logic [ADDR_W-1:0] OFF_DATA = ADDR64 ? OFF_DATA64 : OFF_DATA32;
   localparam logic [ADDR_W-1:0] OFF_MASK = ADDR64 ? OFF_MASK64 : OFF_MASK32;
   localparam logic [ADDR_W-1:0] OFF_PEND = ADDR64 ? OFF_PEND64 : OFF_PEND32;

   msc_state_t st_reg;
   msc_state_t st_next;

   logic [5:0]      nvec;
   logic [NVEC-1:0] vmask;
   logic [15:0]     lowf;
   logic [NVEC-1:0] ready_vec;
   logic [NVEC-1:0] new_req;
   logic [4:0]      pick;
   logic            found;
   logic [31:0]     ctrl_rd;
   logic [31:0]     rd_val;
   logic [31:0]     wm;
   logic [15:0]     msg;
   logic [N_EV-1:0] ev;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // vector count and implemented bits
   always_comb begin
      nvec  = 6'h01 << st_reg.mme;
      vmask = ~(ALL_ONES << nvec);
      lowf  = {11'h000, 5'(nvec - 6'h01)};
   end

   ////////////////////////////////////////////////////////////////////////
   // read decode
   always_comb begin
      ctrl_rd = RST_WORD;
      ctrl_rd[CTRL_EN_BIT] = st_reg.en;
      ctrl_rd[CTRL_MMC_LSB +: 3] = MMC;
      ctrl_rd[CTRL_MME_LSB +: 3] = st_reg.mme;
      ctrl_rd[CTRL_A64_BIT] = ADDR64;
      ctrl_rd[CTRL_PVM_BIT] = 1'b1;
      rd_val = RST_WORD;
      if (I_ADDRESS == OFF_CTRL) begin
         rd_val = ctrl_rd;
      end else if (I_ADDRESS == OFF_ADDR_LO) begin
         rd_val = {st_reg.addr_lo, 2'b00};
      end else if (ADDR64 && I_ADDRESS == OFF_ADDR_HI) begin
         rd_val = st_reg.addr_hi;
      end else if (I_ADDRESS == OFF_DATA) begin
         rd_val = {RST_HALF, st_reg.payload};
      end else if (I_ADDRESS == OFF_MASK) begin
         rd_val = st_reg.mask & vmask;
      end else if (I_ADDRESS == OFF_PEND) begin
         rd_val = st_reg.pend & vmask;
      end else if (I_ADDRESS == OFF_EV_STS) begin
         rd_val = {29'h0000_0000, st_reg.sts};
      end else if (I_ADDRESS == OFF_EV_IEN) begin
         rd_val = {29'h0000_0000, st_reg.ien};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lowest ready vector; unmasked, implemented and pending
   always_comb begin
      ready_vec = st_reg.pend & ~st_reg.mask & vmask;
      pick  = 5'h00;
      found = 1'b0;
      for (int i = NVEC - 1; i >= 0; i--) begin
         if (ready_vec[i]) begin
            pick  = 5'(i);
            found = 1'b1;
         end
      end
      msg = (st_reg.payload & ~lowf) | ({11'h000, pick} & lowf);
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_next = st_reg;
      wm      = merge(RST_WORD, I_WRITEDATA, I_BYTEENABLE);
      ev      = '0;
      new_req = I_VEC_REQ & vmask;

      // one wait cycle, then a single ack cycle per request
      unique case (st_reg.bus)
         BUS_IDLE: begin
            if (I_READ || I_WRITE) begin
               st_next.bus    = BUS_ACK;
               st_next.wreq   = 1'b0;
               st_next.rdata  = I_READ ? rd_val : RST_WORD;
            end
         end
         BUS_ACK: begin
            st_next.bus    = BUS_IDLE;
            st_next.wreq   = 1'b1;
            if (I_WRITE) begin
               if (I_ADDRESS == OFF_CTRL) begin
                  wm = merge(ctrl_rd, I_WRITEDATA, I_BYTEENABLE);
                  st_next.en = wm[CTRL_EN_BIT];
                  // a count above the capability is held at the capability
                  st_next.mme = (wm[CTRL_MME_LSB +: 3] > MMC) ?
                                MMC : wm[CTRL_MME_LSB +: 3];
               end else if (I_ADDRESS == OFF_ADDR_LO) begin
                  wm = merge({st_reg.addr_lo, 2'b00}, I_WRITEDATA,
                             I_BYTEENABLE);
                  st_next.addr_lo = wm[31:AL_LSB];
               end else if (ADDR64 && I_ADDRESS == OFF_ADDR_HI) begin
                  st_next.addr_hi = merge(st_reg.addr_hi, I_WRITEDATA,
                                          I_BYTEENABLE);
               end else if (I_ADDRESS == OFF_DATA) begin
                  wm = merge({RST_HALF, st_reg.payload}, I_WRITEDATA,
                             I_BYTEENABLE);
                  st_next.payload = wm[15:0];
               end else if (I_ADDRESS == OFF_MASK) begin
                  st_next.mask = merge(st_reg.mask, I_WRITEDATA,
                                       I_BYTEENABLE) & vmask;
               end else if (I_ADDRESS == OFF_EV_CLR) begin
                  st_next.sts = st_reg.sts & ~wm[N_EV-1:0];
               end else if (I_ADDRESS == OFF_EV_IEN) begin
                  wm = merge({29'h0000_0000, st_reg.ien}, I_WRITEDATA,
                             I_BYTEENABLE);
                  st_next.ien = wm[N_EV-1:0];
               end
            end
         end
      endcase

      // write port: hold until accepted
      if (st_reg.mwr_valid && I_MWR_READY) begin
         st_next.mwr_valid = 1'b0;
      end
      if (!st_reg.mwr_valid && st_reg.en && found) begin
         st_next.mwr_valid = 1'b1;
         st_next.mwr_addr  = {ADDR64 ? st_reg.addr_hi : RST_WORD,
                              st_reg.addr_lo, 2'b00};
         st_next.mwr_data  = {RST_HALF, msg};
         st_next.pend[pick] = 1'b0;
         ev[EV_SENT] = 1'b1;
      end

      // set after clear so a same-cycle raise is kept
      if (st_reg.en) begin
         st_next.pend = st_next.pend | new_req;
         ev[EV_HELD] = |(new_req & st_reg.mask);
      end
      ev[EV_DROP] = |(I_VEC_REQ & ~(st_reg.en ? vmask : RST_WORD));
      st_next.pend = st_next.pend & vmask;

      st_next.sts = st_next.sts | ev;
      st_next.irq = |(st_next.sts & st_next.ien);
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_reg.bus       <= BUS_IDLE;
         st_reg.wreq      <= 1'b1;
         st_reg.rdata     <= RST_WORD;
         st_reg.en        <= 1'b0;
         st_reg.mme       <= 3'h0;
         st_reg.addr_lo   <= 30'h0000_0000;
         st_reg.addr_hi   <= RST_WORD;
         st_reg.payload   <= RST_HALF;
         st_reg.mask      <= RST_WORD;
         st_reg.pend      <= RST_WORD;
         st_reg.sts       <= '0;
         st_reg.ien       <= '0;
         st_reg.irq       <= 1'b0;
         st_reg.mwr_valid <= 1'b0;
         st_reg.mwr_addr  <= 64'h0000_0000_0000_0000;
         st_reg.mwr_data  <= RST_WORD;
      end else begin
         st_reg <= st_next;
      end
   end

   // waitrequest is a flop of its own, low only in the ack cycle
   assign O_WAITREQUEST = st_reg.wreq;
   assign O_READDATA    = st_reg.rdata;
   assign O_MWR_VALID   = st_reg.mwr_valid;
   assign O_MWR_ADDR    = st_reg.mwr_addr;
   assign O_MWR_DATA    = st_reg.mwr_data;
   assign O_IRQ         = st_reg.irq;

endmodule // msc_msi_cap

// ### hdl/msc_pkg.sv
// constants, types and state layout of the message interrupt capability
// assumes a 200 MHz core clock and a word-wide register bus
// How it works
// - address bits 1:0 read zero, ignore writes
// - lower address bits 31:2 writable, reset zero
// - 64-bit mode: upper word joins lower address
// - 32-bit mode: upper address reads zero
// - data at 0x05C (64-bit) else 0x058
// - send data-derived value to programmed address
// - one vector: data sent unchanged
// - two vectors: bit 0 carries vector number
// - more vectors widen the replaced low field
// - mask at 0x060 (64-bit) else 0x05C
// - only enabled vectors' mask bits writable
// - masked vector is never sent
// - pending at 0x064 (64-bit) else 0x060
// - pending one means vector held in core
// - only enabled vectors' pending bits exist
// - enable bit 16 gates all sends
// - count code 000..101 selects 1..32 vectors
// - read-only bit 23 flags 64-bit addressing
package msc_pkg;

   localparam int ADDR_W = 9;
   localparam int NVEC   = 32;
   localparam int N_EV   = 3;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 9'h050;
   localparam logic [ADDR_W-1:0] OFF_ADDR_LO = 9'h054;
   localparam logic [ADDR_W-1:0] OFF_ADDR_HI = 9'h058;
   localparam logic [ADDR_W-1:0] OFF_DATA64 = 9'h05C;
   localparam logic [ADDR_W-1:0] OFF_DATA32 = 9'h058;
   localparam logic [ADDR_W-1:0] OFF_MASK64 = 9'h060;
   localparam logic [ADDR_W-1:0] OFF_MASK32 = 9'h05C;
   localparam logic [ADDR_W-1:0] OFF_PEND64 = 9'h064;
   localparam logic [ADDR_W-1:0] OFF_PEND32 = 9'h060;
   localparam logic [ADDR_W-1:0] OFF_EV_STS = 9'h100;
   localparam logic [ADDR_W-1:0] OFF_EV_CLR = 9'h104;
   localparam logic [ADDR_W-1:0] OFF_EV_IEN = 9'h108;

   ////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int CTRL_EN_BIT  = 16;
   localparam int CTRL_MMC_LSB = 17;
   localparam int CTRL_MME_LSB = 20;
   localparam int CTRL_A64_BIT = 23;
   localparam int CTRL_PVM_BIT = 24;
   localparam int AL_LSB       = 2;
   localparam logic [2:0] MME_MAX = 3'h5;

   // event bits of the status register
   localparam int EV_SENT = 0;
   localparam int EV_DROP = 1;
   localparam int EV_HELD = 2;

   // reset values and an all-ones mask base
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [15:0] RST_HALF  = 16'h0000;
   localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } msc_bus_t;

   typedef struct packed {
      msc_bus_t          bus;
      logic              wreq;
      logic [31:0]       rdata;
      logic              en;
      logic [2:0]        mme;
      logic [31:2]       addr_lo;
      logic [31:0]       addr_hi;
      logic [15:0]       payload;
      logic [NVEC-1:0]   mask;
      logic [NVEC-1:0]   pend;
      logic [N_EV-1:0]   sts;
      logic [N_EV-1:0]   ien;
      logic              irq;
      logic              mwr_valid;
      logic [63:0]       mwr_addr;
      logic [31:0]       mwr_data;
   } msc_state_t;

endpackage

// ### verification/msc_msi_cap_asserts.sv
// checker for the capability's register bus and interrupt write port
// bound to msc_msi_cap; sees its top ports only, one clock domain
`timescale 1ns/1ps
module msc_msi_cap_asserts (
   input wire logic        I_CLK,
   input wire logic        I_RSTN,
   input wire logic        I_READ,
   input wire logic        I_WRITE,
   input wire logic        O_WAITREQUEST,
   input wire logic [31:0] O_READDATA,
   input wire logic        O_MWR_VALID,
   input wire logic [63:0] O_MWR_ADDR,
   input wire logic [31:0] O_MWR_DATA,
   input wire logic        I_MWR_READY,
   input wire logic        O_IRQ
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   reset_quiet_a: assert property (
      !$past(I_RSTN) |-> O_WAITREQUEST && !O_MWR_VALID && !O_IRQ)
      else $error("outputs not quiet after reset");
   bus_answer_a: assert property (
      (I_READ || I_WRITE) && O_WAITREQUEST |-> ##[1:2] !O_WAITREQUEST)
      else $error("bus request not answered");
   wait_pulse_a: assert property (
      !O_WAITREQUEST |=> O_WAITREQUEST)
      else $error("waitrequest low too long");
   rdata_hold_a: assert property (
      O_WAITREQUEST && !(I_READ || I_WRITE) |=> $stable(O_READDATA))
      else $error("read data moved while idle");
   mwr_hold_a: assert property (
      O_MWR_VALID && !I_MWR_READY |=> O_MWR_VALID && $stable(O_MWR_ADDR)
         && $stable(O_MWR_DATA))
      else $error("interrupt write changed while stalled");
   mwr_gap_a: assert property (
      O_MWR_VALID && I_MWR_READY |=> !O_MWR_VALID)
      else $error("no idle cycle after interrupt write");
   data_field_a: assert property (
      O_MWR_VALID |-> O_MWR_DATA[31:16] == 16'h0000)
      else $error("interrupt data above bit 15");
   addr_align_a: assert property (
      O_MWR_VALID |-> O_MWR_ADDR[1:0] == 2'b00)
      else $error("interrupt address not word aligned");
   cover property (O_MWR_VALID && I_MWR_READY);
   cover property (O_MWR_VALID && !I_MWR_READY);
   cover property ($rose(O_IRQ));
endmodule // msc_msi_cap_asserts

bind msc_msi_cap msc_msi_cap_asserts i_msc_msi_cap_asserts (
   .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_READ(I_READ), .I_WRITE(I_WRITE),
   .O_WAITREQUEST(O_WAITREQUEST), .O_READDATA(O_READDATA),
   .O_MWR_VALID(O_MWR_VALID), .O_MWR_ADDR(O_MWR_ADDR),
   .O_MWR_DATA(O_MWR_DATA), .I_MWR_READY(I_MWR_READY), .O_IRQ(O_IRQ));

// ### verification/msc_rp_model.sv
// root port model: takes interrupt memory writes, can stall on command
// same clock as the capability; the bench drives the stall control
`timescale 1ns/1ps
module msc_rp_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_stall,
   input  wire logic        i_valid,
   input  wire logic [63:0] i_addr,
   input  wire logic [31:0] i_data,
   output logic             o_ready,
   output logic [63:0]      o_last_addr,
   output logic [31:0]      o_last_data,
   output int               o_count
);
   assign o_ready = !i_stall;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count <= 0;
         o_last_addr <= 64'h0000_0000_0000_0000;
         o_last_data <= 32'h0000_0000;
      end else if (i_valid && o_ready) begin
         o_count <= o_count + 1;
         o_last_addr <= i_addr;
         o_last_data <= i_data;
      end
   end
endmodule // msc_rp_model

// ### verification/msi_message_capability_tb.sv
// self-checking bench: register rows, then vector sends and interrupts
// the capability uses its default 64-bit, 32-vector parameters
`timescale 1ns/1ps
module msi_message_capability_tb;
   import msc_pkg::*;
   typedef struct {logic we; logic [ADDR_W-1:0] a;
                   logic [31:0] d, e;} msc_row_t;
   localparam logic [31:0] ZW = 32'h0000_0000;
   logic clk, rst_n, rd, wr, wreq, valid, ready, stall, irq;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wd, rdata, mdata, ldata, r;
   logic [NVEC-1:0] vreq;
   logic [63:0] maddr, laddr;
   int cnt, exp_cnt, num_errors, n_compared;
   msc_row_t rows [15] = '{
      '{1'b0, OFF_ADDR_LO, ZW, ZW}, '{1'b0, OFF_ADDR_HI, ZW, ZW},
      '{1'b0, OFF_DATA64, ZW, ZW}, '{1'b0, OFF_MASK64, ZW, ZW},
      '{1'b0, OFF_PEND64, ZW, ZW}, '{1'b0, OFF_CTRL, ZW, 32'h018A_0000},
      '{1'b1, OFF_ADDR_LO, 32'hFFFF_FFFF, 32'hFFFF_FFFC},
      '{1'b1, OFF_ADDR_HI, 32'h1234_5678, 32'h1234_5678},
      '{1'b1, OFF_DATA64, 32'hFFFF_ABCE, 32'h0000_ABCE},
      '{1'b1, OFF_CTRL, 32'h0021_0000, 32'h01AB_0000},
      '{1'b1, OFF_MASK64, 32'hFFFF_FFFF, 32'h0000_000F},
      '{1'b1, OFF_MASK64, 32'h0000_0004, 32'h0000_0004},
      '{1'b1, OFF_PEND64, 32'hFFFF_FFFF, ZW},
      '{1'b1, 9'h0FC, 32'hFFFF_FFFF, ZW},
      '{1'b1, OFF_EV_IEN, 32'h0000_0007, 32'h0000_0007}};
   msc_msi_cap i_msc_msi_cap (
      .I_CLK(clk), .I_RSTN(rst_n), .I_ADDRESS(addr), .I_READ(rd),
      .I_WRITE(wr), .I_WRITEDATA(wd), .I_BYTEENABLE(4'hF),
      .O_WAITREQUEST(wreq), .O_READDATA(rdata), .I_VEC_REQ(vreq),
      .O_MWR_VALID(valid), .O_MWR_ADDR(maddr), .O_MWR_DATA(mdata),
      .I_MWR_READY(ready), .O_IRQ(irq));
   msc_rp_model i_msc_rp_model (
      .i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(valid),
      .i_addr(maddr), .i_data(mdata), .o_ready(ready),
      .o_last_addr(laddr), .o_last_data(ldata), .o_count(cnt));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) num_errors++;
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // a negative vector only waits for a send already under way
   task automatic fire(input int v, input logic [31:0] e, input int sends);
      if (v >= 0) begin
         @(posedge clk);
         vreq[v] <= 1'b1;
         @(posedge clk);
         vreq <= '0;
      end
      exp_cnt += sends;
      for (int n = 0; n < 12 && !(sends > 0 && cnt == exp_cnt); n++)
         @(posedge clk);
      chk("sends", 64'(cnt), 64'(exp_cnt));
      if (sends > 0) chk("payload", ldata, e);
   endtask
   task automatic stop_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test;
   end
   initial begin
      {rst_n, rd, wr, stall, addr, wd, vreq} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].we) bus(1'b1, rows[i].a, rows[i].d, r);
         bus(1'b0, rows[i].a, ZW, r);
         chk("reg", r, rows[i].e);
      end
      fire(1, 32'h0000_ABCD, 1);
      chk("addr", laddr, 64'h1234_5678_FFFF_FFFC);
      fire(2, ZW, 0);
      bus(1'b0, OFF_PEND64, ZW, r);
      chk("pend", r, 32'h0000_0004);
      bus(1'b1, OFF_MASK64, ZW, r);
      fire(-1, 32'h0000_ABCE, 1);
      bus(1'b0, OFF_PEND64, ZW, r);
      chk("pend", r, ZW);
      fire(5, ZW, 0);
      bus(1'b1, OFF_CTRL, 32'h0011_0000, r);
      fire(1, 32'h0000_ABCF, 1);
      bus(1'b1, OFF_CTRL, 32'h0001_0000, r);
      fire(0, 32'h0000_ABCE, 1);
      bus(1'b1, OFF_MASK64, 32'hFFFF_FFFF, r);
      bus(1'b0, OFF_MASK64, ZW, r);
      chk("mask", r, 32'h0000_0001);
      bus(1'b1, OFF_MASK64, ZW, r);
      stall <= 1'b1;
      fire(0, ZW, 0);
      chk("stalled", valid, 1'b1);
      stall <= 1'b0;
      fire(-1, 32'h0000_ABCE, 1);
      bus(1'b1, OFF_CTRL, ZW, r);
      fire(0, ZW, 0);
      chk("irq", irq, 1'b1);
      bus(1'b1, OFF_EV_IEN, ZW, r);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      bus(1'b0, OFF_EV_STS, ZW, r);
      chk("status", r, 32'h0000_0007);
      bus(1'b1, OFF_EV_IEN, 32'h0000_0007, r);
      bus(1'b1, OFF_EV_CLR, 32'h0000_0007, r);
      repeat (2) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      stop_test;
   end
endmodule // msi_message_capability_tb
